// File: test/snv_master_model.sv
/*
 two-wire bus master model: drives the bus clock and its share of data.
 assumes clk_sys at 50 ns and the bench resolving the data line.
*/
`timescale 1ns/10ps
module snv_master_model (
   input wire logic clk_sys,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   // -------------------------------------------------
   // idle bus
   // -------------------------------------------------
   // clock is ours, parked high between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // -------------------------------------------------
   // framing
   // -------------------------------------------------
   // data falls while clock high
   task automatic start();
      if (scl === 1'b0) begin
         tk(2);
         sda_drv = 1'b1;
         tk(2);
         scl = 1'b1;
         tk(4);
      end
      sda_drv = 1'b0;
      tk(4);
      scl = 1'b0;
   endtask

   task automatic stop();
      tk(2);
      sda_drv = 1'b0;
      tk(2);
      scl = 1'b1;
      tk(4);
      sda_drv = 1'b1;
      tk(4);
   endtask

   // -------------------------------------------------
   // bits and bytes
   // -------------------------------------------------
   // data moves mid-low, sampled mid-high; 400 ns period
   task automatic xbit(input logic b, output logic r);
      tk(2);
      sda_drv = b;
      tk(2);
      scl = 1'b1;
      tk(2);
      r = sda_line;
      tk(2);
      scl = 1'b0;
   endtask

   // msb first, ninth clock is acknowledge
   task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(ack_in, ack);
   endtask
endmodule // snv_master_model

// File: test/tb_top.sv
/*
 self-checking bench for the two-wire memory slave.
 assumes snv_master_model on the far side and a pull-up on data.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import snv_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] device_select_pins = 3'h5;
   logic write_protect = 1'b0;
   logic scl, sda_drv, sda_out, sda_oe_n, busy;
   wire sda_line;
   int miscompares = 0;
   int n_tests = 0;
   logic [7:0] q;
   logic a;

   always #25 clk_sys = ~clk_sys;
   // low wins, pull-up otherwise
   assign sda_line = sda_drv & (sda_oe_n | sda_out);

   snv_slave u_snv_slave (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins),
      .write_protect(write_protect), .busy(busy));
   snv_master_model u_snv_master_model (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
      .sda_drv(sda_drv));

   // -------------------------------------------------
   // shared steps
   // -------------------------------------------------
   task automatic summarize();
      $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wb(input logic [7:0] d, input logic exp_ack);
      u_snv_master_model.xbyte(d, 1'b1, q, a);
      `CHK(a, exp_ack)
   endtask

   task automatic rb(input logic [7:0] e, input logic last);
      u_snv_master_model.xbyte(8'hff, last, q, a);
      `CHK(q, e)
   endtask

   // bounded wait for standby after stop
   task automatic end_idle();
      int i;
      u_snv_master_model.stop();
      for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys);
      `CHK(busy, 1'b0)
      if (busy !== 1'b0) summarize();
   endtask

   // address high byte first, top three bits sent as zero
   task automatic addr_phase(input logic [12:0] ad);
      u_snv_master_model.start();
      wb({SNV_TYPE_DEFAULT, device_select_pins, 1'b0}, 1'b0);
      wb({3'h0, ad[12:8]}, 1'b0);
      wb(ad[7:0], 1'b0);
   endtask

   task automatic rd_hdr();
      u_snv_master_model.start();
      wb({SNV_TYPE_DEFAULT, device_select_pins, 1'b1}, 1'b0);
   endtask

   task automatic rd_at(input logic [12:0] ad, input logic [7:0] e);
      addr_phase(ad);
      rd_hdr();
      rb(e, 1'b1);
      end_idle();
   endtask

   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task automatic sc_reset();
      `CHK(busy, 1'b0)
      `CHK(sda_oe_n, 1'b1)
      `CHK(sda_out, 1'b0)
   endtask

   // two-byte write, then reads with no wait after stop
   task automatic sc_write_read();
      addr_phase(13'h0123);
      wb(8'ha5, 1'b0);
      wb(8'h5a, 1'b0);
      end_idle();
      rd_at(13'h0123, 8'ha5);
      rd_at(13'h0124, 8'h5a);
   endtask

   // every strap value, a neighbour code and a foreign type code
   task automatic sc_select();
      for (int p = 0; p < 8; p++) begin
         device_select_pins = p[2:0];
         u_snv_master_model.tk(4);
         u_snv_master_model.start();
         wb({SNV_TYPE_DEFAULT, p[2:0], 1'b0}, 1'b0);
         end_idle();
         u_snv_master_model.start();
         wb({SNV_TYPE_DEFAULT, p[2:0] ^ 3'h1, 1'b0}, 1'b1);
         wb(8'h00, 1'b1);
         end_idle();
         u_snv_master_model.start();
         wb({SNV_TYPE_DEFAULT ^ 4'h8, p[2:0], 1'b0}, 1'b1);
         end_idle();
      end
      device_select_pins = 3'h5;
      u_snv_master_model.tk(4);
   endtask

   // protected write is acked but leaves the array alone
   task automatic sc_protect();
      write_protect = 1'b1;
      u_snv_master_model.tk(4);
      addr_phase(13'h0123);
      wb(8'h3c, 1'b0);
      end_idle();
      rd_at(13'h0123, 8'ha5);
      write_protect = 1'b0;
      u_snv_master_model.tk(4);
   endtask

   // page write across the top, sequential and current-address reads
   task automatic sc_wrap();
      addr_phase(SNV_ADDR_LAST);
      wb(8'h11, 1'b0);
      wb(8'h22, 1'b0);
      wb(8'h33, 1'b0);
      end_idle();
      addr_phase(SNV_ADDR_LAST);
      rd_hdr();
      rb(8'h11, 1'b0);
      rb(8'h22, 1'b1);
      end_idle();
      rd_hdr();
      rb(8'h33, 1'b1);
      end_idle();
   endtask

   // stop inside a data byte discards the partial byte
   task automatic sc_stop_mid();
      addr_phase(13'h0123);
      for (int i = 0; i < 4; i++) u_snv_master_model.xbit(1'b1, a);
      end_idle();
      rd_at(13'h0123, 8'ha5);
   endtask

   initial begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      sc_reset();
      sc_write_read();
      sc_select();
      sc_protect();
      sc_wrap();
      sc_stop_mid();
      summarize();
   end
endmodule // tb_top

// File: verilog/snv_fifo.sv
/*
 small flop-based fifo with valid/ready on both sides.
 assumes one clock domain; depth is a power of two.
*/
`timescale 1ns/10ps
module snv_fifo import snv_pkg::*; #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW:0] wr_ff;
   logic [PW:0] rd_ff;
   logic push;
   logic pop;

   assign in_ready = (wr_ff - rd_ff) != (PW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_ff[rd_ff[PW-1:0]];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop) rd_ff <= rd_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) mem_ff[wr_ff[PW-1:0]] <= in_data;
   end
endmodule // snv_fifo

// File: verilog/snv_pkg.sv
/*
 two-wire nonvolatile memory slave: shared constants and types.
 assumes a single system clock domain; bus pins arrive asynchronously.
*/
package snv_pkg;
   // -------------------------------------------------
   // array geometry
   // -------------------------------------------------
   localparam int SNV_DEPTH = 8192;
   localparam int SNV_AW = 13;
   localparam int SNV_DW = 8;
   localparam logic [12:0] SNV_ADDR_ZERO = 13'h0000;
   localparam logic [12:0] SNV_ADDR_LAST = 13'h1fff;
   // -------------------------------------------------
   // select byte layout
   // -------------------------------------------------
   localparam int SNV_TYPE_MSB = 7;
   localparam int SNV_TYPE_LSB = 4;
   localparam int SNV_SEL_MSB = 3;
   localparam int SNV_SEL_LSB = 1;
   localparam int SNV_RW_BIT = 0;
   // arbitrary neutral value, overridable
   localparam logic [3:0] SNV_TYPE_DEFAULT = 4'h5;
   // -------------------------------------------------
   // bit counting, fifo depth, sync stages
   // -------------------------------------------------
   localparam logic [3:0] SNV_BIT_LAST = 4'h7;
   localparam logic [3:0] SNV_BIT_ZERO = 4'h0;
   localparam int SNV_FIFO_DEPTH = 16;
   localparam int SNV_SYNC_STAGES = 2;
   // -------------------------------------------------
   // protocol state
   // -------------------------------------------------
   typedef enum logic [3:0] {
      SNV_IDLE, SNV_DEV, SNV_DEV_ACK, SNV_AHI, SNV_AHI_ACK, SNV_ALO, SNV_ALO_ACK,
      SNV_WDAT, SNV_WDAT_ACK, SNV_RDAT, SNV_RDAT_ACK
   } snv_state_t;
endpackage

// File: verilog/snv_slave.sv
/*
 two-wire serial slave of a byte-organised nonvolatile memory, 8192 x 8.
 assumes an external master drives the bus clock and a pull-up on data;
 all pins are asynchronous to clk_sys, which must run well above the bus.
*/
// Notes on behaviour
// R1: array holds 8192 bytes, each individually addressed.
// R2: act only when received select bits equal the select pins.
// R3: unconnected select pins read low through internal pull-downs.
// R4: data line is open drain: driven low or released.
// R5: sample data on clock rise, change output on clock fall.
// R6: protect high refuses every write, memory unchanged.
// R7: protect low allows writes to every location.
// R8: reads work whatever the protect level.
// R9: unconnected protect input reads low, writes enabled.
// R10: slave only; never drives the clock nor starts transfers.
// R11: master starts every transfer and supplies the clock.
// R12: data changes only while clock low, except start and stop.
// R13: data falling while clock high is a start.
// R14: data rising while clock high is a stop; ends read, standby.
// R15: stop ends incoming write data and returns to standby.
// R16: after a write stop, a new transaction is taken at once.
// R17: first byte: type code, three select bits, read/write bit.
// R18: receiver pulls data low on ninth clock; transmitter releases.
// R19: master sends 13-bit address, high byte first, top bits zero.
// R20: address advances per byte, wraps to zero; commit after acknowledge.
// R21: in standby or after mismatch, ignore bus, keep data released.
`timescale 1ns/10ps
module snv_slave import snv_pkg::*; #(
   parameter logic [3:0] TYPE_CODE = SNV_TYPE_DEFAULT,
   parameter int FIFO_DEPTH = SNV_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // R3 R9: pins assumed to resolve low when open (pull-down in the pad)
   input wire logic [2:0] device_select_pins,
   input wire logic write_protect,
   output logic busy
);
   // -------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------
   logic [5:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic [2:0] sel_s;
   // reset at the bus idle level: no false clock edge follows reset
   localparam logic [5:0] PINS_IDLE = 6'h03;
   snv_sync #(.WIDTH(6), .RST_VAL(PINS_IDLE)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in({write_protect, device_select_pins, sda_in, scl_in}),
      .sync_out(pins_s)
   );
   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[4:2];
   assign wp_s = pins_s[5];

   logic scl_d_ff;
   logic sda_d_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // -------------------------------------------------
   // edge and condition detect
   // -------------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   // R13: start = data falls with clock high
   assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
   // R14: stop = data rises with clock high
   assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   // -------------------------------------------------
   // protocol state
   // -------------------------------------------------
   snv_state_t st_ff;
   snv_state_t nxt_st;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [SNV_AW-1:0] addr_ff;
   logic [SNV_DW-1:0] tx_ff;
   logic drive_low_ff;
   logic rd_nack_ff;
   logic [7:0] rx_byte;
   logic byte_done;
   logic sel_match;
   logic is_ack_st;
   logic ack_end;
   // count reached after the ninth rise of an ack clock
   localparam logic [3:0] ACK_BIT = 4'h9;

   assign rx_byte = {sh_ff[6:0], sda_s};
   assign byte_done = scl_rise && (bit_ff == SNV_BIT_LAST);
   // R2 R17: type code and select pins must both match
   assign sel_match = (rx_byte[SNV_TYPE_MSB:SNV_TYPE_LSB] == TYPE_CODE) &&
      (rx_byte[SNV_SEL_MSB:SNV_SEL_LSB] == sel_s);
   assign is_ack_st = (st_ff == SNV_DEV_ACK) || (st_ff == SNV_AHI_ACK) ||
      (st_ff == SNV_ALO_ACK) || (st_ff == SNV_WDAT_ACK);
   // R18: an ack clock ends at its own fall, not at the fall of the eighth bit
   assign ack_end = scl_fall && (is_ack_st ? bit_ff == ACK_BIT : st_ff == SNV_RDAT_ACK);

   // -------------------------------------------------
   // write path through fifo into the array
   // -------------------------------------------------
   logic wq_valid;
   logic wq_ready;
   logic [SNV_AW+SNV_DW-1:0] wq_data;
   logic mq_valid;
   logic [SNV_AW+SNV_DW-1:0] mq_data;
   logic [SNV_DW-1:0] wr_byte_ff;
   logic commit;
   logic [SNV_DW-1:0] mem_ff [SNV_DEPTH];

   // R6 R7: queue the byte only while unprotected; R20 commit at ack end
   assign commit = (st_ff == SNV_WDAT_ACK) && ack_end;
   assign wq_valid = commit && !wp_s;
   assign wq_data = {addr_ff, wr_byte_ff};

   snv_fifo #(.WIDTH(SNV_AW + SNV_DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(wq_valid),
      .in_ready(wq_ready),
      .in_data(wq_data),
      .out_valid(mq_valid),
      .out_ready(1'b1),
      .out_data(mq_data)
   );

   // R1: 8192 byte array, one byte drained per cycle
   always_ff @(posedge clk_sys) begin
      if (mq_valid) mem_ff[mq_data[SNV_AW+SNV_DW-1:SNV_DW]] <= mq_data[SNV_DW-1:0];
   end

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         SNV_IDLE: nxt_st = SNV_IDLE;
         SNV_DEV: if (byte_done) nxt_st = sel_match ? SNV_DEV_ACK : SNV_IDLE;
         SNV_DEV_ACK: if (ack_end) nxt_st = sh_ff[SNV_RW_BIT] ? SNV_RDAT : SNV_AHI;
         SNV_AHI: if (byte_done) nxt_st = SNV_AHI_ACK;
         SNV_AHI_ACK: if (ack_end) nxt_st = SNV_ALO;
         SNV_ALO: if (byte_done) nxt_st = SNV_ALO_ACK;
         SNV_ALO_ACK: if (ack_end) nxt_st = SNV_WDAT;
         SNV_WDAT: if (byte_done) nxt_st = SNV_WDAT_ACK;
         // fifo full stalls acceptance: nack and drop to standby
         SNV_WDAT_ACK: if (ack_end) nxt_st = wq_ready ? SNV_WDAT : SNV_IDLE;
         SNV_RDAT: if (scl_fall && bit_ff == SNV_BIT_LAST) nxt_st = SNV_RDAT_ACK;
         SNV_RDAT_ACK: if (scl_fall) nxt_st = rd_nack_ff ? SNV_IDLE : SNV_RDAT;
         default: nxt_st = SNV_IDLE;
      endcase
      // R14 R15 R16: stop always ends in standby, ready for next start
      if (stop_det) nxt_st = SNV_IDLE;
      // R13: start restarts from any state, repeated start included
      if (start_det) nxt_st = SNV_DEV;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) st_ff <= SNV_IDLE;
      else st_ff <= nxt_st;
   end

   // -------------------------------------------------
   // bit counter, shifter, address
   // -------------------------------------------------
   // R5: capture on rising clock edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bit_ff <= SNV_BIT_ZERO;
         sh_ff <= 8'h00;
      end else if (start_det || ack_end) begin
         bit_ff <= SNV_BIT_ZERO;
      end else if (is_ack_st) begin
         // ack clocks count rises only; the shifter keeps the received byte
         if (scl_rise) bit_ff <= bit_ff + 4'h1;
      end else if (st_ff == SNV_RDAT || st_ff == SNV_RDAT_ACK) begin
         // outgoing bits are counted on falls alone
         if (scl_fall) bit_ff <= bit_ff + 4'h1;
      end else if (scl_rise) begin
         sh_ff <= rx_byte;
         bit_ff <= bit_ff + 4'h1;
      end
   end

   // R20: address loads high then low, advances per byte, wraps to zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff <= SNV_ADDR_ZERO;
         wr_byte_ff <= 8'h00;
      end else if (byte_done && st_ff == SNV_AHI) begin
         // R19: upper three bits ignored
         addr_ff <= {rx_byte[SNV_AW-9:0], addr_ff[7:0]};
      end else if (byte_done && st_ff == SNV_ALO) begin
         addr_ff <= {addr_ff[SNV_AW-1:8], rx_byte};
      end else if (byte_done && st_ff == SNV_WDAT) begin
         wr_byte_ff <= rx_byte;
      end else if (commit || (st_ff == SNV_RDAT_ACK && scl_rise)) begin
         // R6: protected bytes are acknowledged but address still advances
         addr_ff <= (addr_ff == SNV_ADDR_LAST) ? SNV_ADDR_ZERO : addr_ff + 13'h0001;
      end
   end

   // -------------------------------------------------
   // data line drive
   // -------------------------------------------------
   logic load_tx;
   assign load_tx = ack_end && ((st_ff == SNV_DEV_ACK && sh_ff[SNV_RW_BIT]) ||
      (st_ff == SNV_RDAT_ACK && !rd_nack_ff));

   // R8: read path ignores protect; R5 output shifts on falling edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_ff <= 8'h00;
         drive_low_ff <= 1'b0;
         rd_nack_ff <= 1'b0;
      end else begin
         if (st_ff == SNV_RDAT_ACK && scl_rise) rd_nack_ff <= sda_s;
         if (load_tx) begin
            tx_ff <= {mem_ff[addr_ff][6:0], 1'b0};
            drive_low_ff <= !mem_ff[addr_ff][7];
         end else if (nxt_st == SNV_RDAT && scl_fall) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            drive_low_ff <= !tx_ff[7];
         // R18: pull low for ack on the ninth clock, release otherwise
         end else if (byte_done && (st_ff == SNV_DEV ? sel_match :
               (st_ff == SNV_AHI || st_ff == SNV_ALO || st_ff == SNV_WDAT))) begin
            drive_low_ff <= 1'b0;
         end else if (scl_fall) begin
            drive_low_ff <= (nxt_st == SNV_DEV_ACK || nxt_st == SNV_AHI_ACK ||
               nxt_st == SNV_ALO_ACK || (nxt_st == SNV_WDAT_ACK && wq_ready));
         end
         // R21 R14: standby releases the line immediately
         if (nxt_st == SNV_IDLE || start_det) drive_low_ff <= 1'b0;
      end
   end

   // R4 R12: open drain, changes only on falling clock; R10 no clock drive
   assign sda_out = 1'b0;
   assign sda_oe_n = !drive_low_ff;
   assign busy = st_ff != SNV_IDLE;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   sequence s_stop;
      stop_det;
   endsequence
   sequence s_byte_in;
      byte_done && st_ff == SNV_WDAT;
   endsequence
   sequence s_ack_clk;
      st_ff == SNV_WDAT_ACK && scl_rise && wq_ready;
   endsequence

   chk_stop_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
      s_stop |=> st_ff == SNV_IDLE) else $error("stop did not return to standby");
   chk_wp_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
      wq_valid |-> !wp_s) else $error("write queued while protected");
   chk_wr_commit: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
      commit && !wp_s && wq_ready |-> wq_valid) else $error("unprotected write dropped");
   chk_idle_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // R21
      st_ff == SNV_IDLE && $past(st_ff) == SNV_IDLE |-> sda_oe_n)
      else $error("line driven in standby");
   chk_sda_stable: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
      $changed(sda_oe_n) |-> !scl_s || !scl_d_ff || $past(start_det || stop_det))
      else $error("data changed while clock high");
   chk_mismatch: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
      byte_done && st_ff == SNV_DEV && !sel_match && !start_det && !stop_det
      |=> st_ff == SNV_IDLE) else $error("mismatched select not ignored");
   chk_ack_drive: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
      s_ack_clk |-> !sda_oe_n)
      else $error("no acknowledge after data byte");
   chk_start_dev: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
      start_det |=> st_ff == SNV_DEV) else $error("start not recognised");
   chk_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // R20
      commit && addr_ff == SNV_ADDR_LAST && !start_det |=> addr_ff == SNV_ADDR_ZERO)
      else $error("address did not wrap");
   chk_wr_byte: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
      s_byte_in |=> wr_byte_ff == $past(rx_byte)) else $error("data byte not captured");
   chk_rd_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
      st_ff == SNV_RDAT_ACK && scl_rise |-> sda_oe_n)
      else $error("line held during master acknowledge");
   chk_rd_nack: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
      ack_end && st_ff == SNV_RDAT_ACK && rd_nack_ff |=> st_ff == SNV_IDLE && sda_oe_n)
      else $error("read went on after nack");
endmodule // snv_slave

// File: verilog/snv_sync.sv
/*
 two-flop synchroniser for asynchronous pins.
 assumes inputs come from outside the clk_sys domain.
*/
`timescale 1ns/10ps
module snv_sync import snv_pkg::*; #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // first stage read only by second stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule // snv_sync
